/* File: include/rstctl_pkg.sv */
// Behaviour
// - Five sources start a reset: power-on, brown-out, watchdog reset, reset pin, debugger bit 0.
// - In stop mode, watchdog time-out, enabled GPIO edge or debug pin low start recovery.
// - Two reset types only, chosen from operating mode and the causing source.
// - System reset clears control registers and CPU; held 66 oscillator plus 16 clock cycles.
// - Stop recovery touches only the watchdog cause register; same 66 plus 16 latency.
// - At system reset start every GPIO becomes input and pull-ups are disabled.
// - CPU and peripherals stay idle through reset while both oscillators keep running.
// - System clock starts after the oscillator count; CPU idle through the 16 clock cycles.
// - Control registers with a defined reset value are loaded; pointers, flags, RAM undefined.
// - Leaving reset, the CPU fetches the vector at program addresses 0002H and 0003H.
// - Power-on or brown-out outranks every other source and always gives a system reset.
// - In normal or halt mode, watchdog (with the reset option selected), power, or pin events give a system reset.
// - Debugger-requested reset resets the whole device except the debugger logic itself.
// - Reset held while supply unsafe; afterwards a counter counts 66 oscillator cycles.
// - Then 16 system-clock pulses are counted; release only after both counters expire.
// - After a power-on reset the power-on cause flag reads 1.
// - Reset pin must be low at least 4 clocks; reset held while pin stays low.
// - After a pin-caused system reset the pin cause flag reads 1.
package rstctl_pkg;

  localparam int CLK_HZ         = 25_000_000;
  localparam int WD_OSC_HZ      = 10_000;
  localparam int WD_DIV_DEFAULT = CLK_HZ / WD_OSC_HZ;

  localparam logic [6:0] WD_OSC_CYCLES  = 7'h42;
  localparam logic [4:0] SYS_CLK_CYCLES = 5'h10;
  localparam logic [2:0] PIN_MIN_CYCLES = 3'h4;

  localparam int GPIO_W = 8;

  localparam logic [11:0] ADDR_WD_CAUSE   = 12'hFF0;
  localparam logic [11:0] ADDR_DEBUG_CTRL = 12'h100;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h104;
  localparam logic [11:0] ADDR_INT_MASK   = 12'h108;

  localparam int DEBUG_RST_BIT = 0;
  localparam int INT_SYS_DONE  = 0;
  localparam int INT_REC_DONE  = 1;
  localparam int CAUSE_LSB     = 4;

  localparam logic [15:0] RESET_VECTOR_HI = 16'h0002;
  localparam logic [15:0] RESET_VECTOR_LO = 16'h0003;

  // supply_low, brownout, reset pin, debug pin seen after release of rst
  localparam logic [3:0] SYNC_PIN_RST = 4'hB;
  localparam logic [1:0] INT_RST      = 2'h0;

  typedef struct packed {
    logic por;
    logic stop;
    logic watchdog;
    logic pin;
  } cause_t;

  localparam cause_t CAUSE_RST = '0;

  typedef struct packed {
    logic sys_reset;
    logic recovery;
    logic cpu_idle;
    logic sysclk_en;
    logic gpio_input;
    logic pullup_off;
  } rst_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_WD   = 4'b0100,
    ST_SYS  = 4'b1000
  } rst_state_t;

endpackage : rstctl_pkg

/* File: rtl/reset_stop_recovery_controller.sv */
`timescale 1ns/1ps
module reset_stop_recovery_controller
  import rstctl_pkg::*;
#(
  parameter int WD_DIV = WD_DIV_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire logic              supply_low,
  input  wire logic              supply_brownout_detect,
  input  wire logic              reset_pin_n,
  input  wire logic              debug_pin,
  input  wire logic [GPIO_W-1:0] gpio_pins,
  input  wire logic [GPIO_W-1:0] gpio_recovery_en,
  input  wire logic              stop_mode,
  input  wire logic              watchdog_timeout,
  input  wire logic              watchdog_reset_select_option,
  output rst_ctrl_t              ctrl,
  output logic      [7:0]        watchdog_control_reset_cause,
  output logic                   vector_fetch,
  output logic      [15:0]       vector_addr_hi,
  output logic      [15:0]       vector_addr_lo,
  output logic                   irq
);

  localparam logic [15:0]        DIV_LAST = 16'(WD_DIV - 1);
  localparam logic [6:0]         WD_LAST  = WD_OSC_CYCLES - 7'h01;
  localparam logic [4:0]         SYS_LAST = SYS_CLK_CYCLES - 5'h01;
  localparam int                 SYNC_W   = 4 + GPIO_W;
  localparam logic [SYNC_W-1:0]  SYNC_RST = {SYNC_PIN_RST, {GPIO_W{1'b0}}};

  logic [SYNC_W-1:0] sy;
  logic              sy_supply_low;
  logic              sy_brownout;
  logic              sy_pin_n;
  logic              sy_debug_pin;
  logic [GPIO_W-1:0] sy_gpio;
  logic [GPIO_W-1:0] gpio_prev_r;
  logic [2:0]        pin_cnt_r;
  logic [15:0]       div_r;
  logic              wd_tick;
  logic              por_req;
  logic              pin_req;
  logic              wd_sys_req;
  logic              sys_req;
  logic              gpio_edge;
  logic              rec_req;
  logic              upgrade;
  logic              finish;
  rst_state_t        state_r;
  logic              is_sys_r;
  cause_t            pend_r;
  cause_t            cause_r;
  logic [6:0]        wcnt_r;
  logic [4:0]        scnt_r;
  logic              debugger_rst_r;
  logic [1:0]        int_status_r;
  logic [1:0]        int_mask_r;
  logic              addr_ph;
  logic              act_r;
  logic              wr_r;
  logic [9:0]        waddr_r;
  logic              wr_en;
  logic [31:0]       hrdata_r;
  logic              vector_fetch_r;

  // pins come from outside the clock domain
  sync_bits #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({supply_low, supply_brownout_detect, reset_pin_n, debug_pin, gpio_pins}),
    .dout (sy)
  );

  assign sy_supply_low = sy[SYNC_W-1];
  assign sy_brownout   = sy[SYNC_W-2];
  assign sy_pin_n      = sy[SYNC_W-3];
  assign sy_debug_pin  = sy[SYNC_W-4];
  assign sy_gpio       = sy[GPIO_W-1:0];

  // the watchdog oscillator is modelled as a free-running divider tick, never gated by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0000;
    end else if (div_r == DIV_LAST) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign wd_tick = (div_r == DIV_LAST);

  // pin filter: short glitches below the minimum never start a reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_cnt_r <= 3'h0;
    end else if (sy_pin_n) begin
      pin_cnt_r <= 3'h0;
    end else if (pin_cnt_r != PIN_MIN_CYCLES) begin
      pin_cnt_r <= pin_cnt_r + 3'h1;
    end
  end
  assign pin_req = (pin_cnt_r == PIN_MIN_CYCLES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_prev_r <= '0;
    end else begin
      gpio_prev_r <= sy_gpio;
    end
  end

  assign por_req    = sy_supply_low | sy_brownout;
  assign wd_sys_req = watchdog_timeout & watchdog_reset_select_option & ~stop_mode;
  assign sys_req    = pin_req | wd_sys_req | debugger_rst_r;
  assign gpio_edge  = |((sy_gpio ^ gpio_prev_r) & gpio_recovery_en);
  assign rec_req    = stop_mode & (watchdog_timeout | gpio_edge | ~sy_debug_pin);
  assign upgrade    = ~is_sys_r & (state_r != ST_IDLE) & sys_req;
  assign finish     = (state_r == ST_SYS) & (scnt_r == SYS_LAST) & sy_pin_n & ~por_req & ~upgrade;

  // power events win over everything, recovery loses to any system source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      is_sys_r <= 1'b0;
      pend_r   <= CAUSE_RST;
      wcnt_r   <= 7'h00;
      scnt_r   <= 5'h00;
    end else if (por_req) begin
      state_r  <= ST_HOLD;
      is_sys_r <= 1'b1;
      pend_r   <= '{por: 1'b1, stop: 1'b0, watchdog: 1'b0, pin: 1'b0};
      wcnt_r   <= 7'h00;
      scnt_r   <= 5'h00;
    end else if (upgrade) begin
      state_r  <= ST_WD;
      is_sys_r <= 1'b1;
      pend_r   <= '{por: debugger_rst_r, stop: 1'b0, watchdog: wd_sys_req, pin: pin_req};
      wcnt_r   <= 7'h00;
      scnt_r   <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sys_req) begin
            state_r  <= ST_WD;
            is_sys_r <= 1'b1;
            pend_r   <= '{por: debugger_rst_r, stop: 1'b0, watchdog: wd_sys_req, pin: pin_req};
            wcnt_r   <= 7'h00;
          end else if (rec_req) begin
            state_r  <= ST_WD;
            is_sys_r <= 1'b0;
            pend_r   <= '{por: 1'b0, stop: 1'b1, watchdog: watchdog_timeout, pin: 1'b0};
            wcnt_r   <= 7'h00;
          end
        end
        ST_HOLD: begin
          state_r <= ST_WD;
          wcnt_r  <= 7'h00;
        end
        ST_WD: begin
          if (is_sys_r) begin
            pend_r.pin <= pend_r.pin | pin_req;
          end
          if (wd_tick) begin
            if (wcnt_r == WD_LAST) begin
              state_r <= ST_SYS;
              scnt_r  <= 5'h00;
            end else begin
              wcnt_r <= wcnt_r + 7'h01;
            end
          end
        end
        ST_SYS: begin
          if (scnt_r != SYS_LAST) begin
            scnt_r <= scnt_r + 5'h01;
          end else if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign ctrl.sys_reset  = is_sys_r & (state_r != ST_IDLE);
  assign ctrl.recovery   = ~is_sys_r & (state_r != ST_IDLE);
  assign ctrl.cpu_idle   = (state_r != ST_IDLE);
  assign ctrl.sysclk_en  = (state_r == ST_IDLE) | (state_r == ST_SYS);
  assign ctrl.gpio_input = ctrl.sys_reset;
  assign ctrl.pullup_off = ctrl.sys_reset;

  // cause flags change only at release, so software never sees a half-updated cause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_r <= CAUSE_RST;
    end else if (finish) begin
      cause_r <= pend_r;
    end
  end
  assign watchdog_control_reset_cause = {cause_r, 4'h0};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_fetch_r <= 1'b0;
    end else begin
      vector_fetch_r <= finish;
    end
  end
  assign vector_fetch   = vector_fetch_r;
  assign vector_addr_hi = RESET_VECTOR_HI;
  assign vector_addr_lo = RESET_VECTOR_LO;

  // AHB-Lite slave, zero wait states
  assign addr_ph = hsel & htrans[1] & hready;
  assign wr_en   = act_r & wr_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_r   <= 1'b0;
      wr_r    <= 1'b0;
      waddr_r <= 10'h000;
    end else begin
      act_r   <= addr_ph;
      wr_r    <= hwrite;
      waddr_r <= haddr[11:2];
    end
  end

  // any system reset clears this once it reaches the oscillator count, so the bit self-clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debugger_rst_r <= 1'b0;
    end else if (wr_en && waddr_r == ADDR_DEBUG_CTRL[11:2] && hwdata[DEBUG_RST_BIT]) begin
      debugger_rst_r <= 1'b1;
    end else if (state_r == ST_WD && is_sys_r) begin
      debugger_rst_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_mask_r <= INT_RST;
    end else if (wr_en && waddr_r == ADDR_INT_MASK[11:2]) begin
      int_mask_r <= hwdata[1:0];
    end
  end

  // new events win over a simultaneous write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status_r <= INT_RST;
    end else begin
      int_status_r[INT_SYS_DONE] <= (finish & is_sys_r) | (int_status_r[INT_SYS_DONE] &
        ~(wr_en && waddr_r == ADDR_INT_STATUS[11:2] && hwdata[INT_SYS_DONE]));
      int_status_r[INT_REC_DONE] <= (finish & ~is_sys_r) | (int_status_r[INT_REC_DONE] &
        ~(wr_en && waddr_r == ADDR_INT_STATUS[11:2] && hwdata[INT_REC_DONE]));
    end
  end
  assign irq = |(int_status_r & int_mask_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_r <= 32'h00000000;
    end else if (addr_ph && !hwrite) begin
      case (haddr[11:2])
        ADDR_WD_CAUSE[11:2]:   hrdata_r <= {24'h000000, cause_r, 4'h0};
        ADDR_DEBUG_CTRL[11:2]: hrdata_r <= {31'h00000000, debugger_rst_r};
        ADDR_INT_STATUS[11:2]: hrdata_r <= {30'h00000000, int_status_r};
        ADDR_INT_MASK[11:2]:   hrdata_r <= {30'h00000000, int_mask_r};
        default:               hrdata_r <= 32'h00000000;
      endcase
    end
  end
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // helper for the oscillator count check
  logic [7:0] h_ticks_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_ticks_r <= 8'h00;
    end else if (state_r != ST_WD || upgrade) begin
      // a restart from recovery begins a fresh oscillator count
      h_ticks_r <= 8'h00;
    end else if (wd_tick) begin
      h_ticks_r <= h_ticks_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_sys_run;
    (state_r == ST_SYS || por_req)[*8];
  endsequence

  sequence seq_sys_entry;
    $past(state_r) == ST_WD && state_r == ST_SYS;
  endsequence

  a_sys_clk_phase: assert property (seq_sys_entry |-> seq_sys_run ##1 seq_sys_run)
    else $error("system clock phase shorter than 16 cycles");
  a_osc_count: assert property (seq_sys_entry |-> h_ticks_r == {1'b0, WD_OSC_CYCLES})
    else $error("oscillator phase not 66 ticks");
  a_por_first: assert property (por_req && state_r != ST_HOLD |=> state_r == ST_HOLD && is_sys_r)
    else $error("power event did not restart a system reset");
  a_idle_reset: assert property (state_r != ST_IDLE |-> ctrl.cpu_idle && !(ctrl.sys_reset && ctrl.recovery))
    else $error("cpu not idle during reset");
  a_gpio_input: assert property (state_r == ST_IDLE && (sys_req || por_req) |=> ctrl.gpio_input && ctrl.pullup_off)
    else $error("gpio not forced at reset start");
  a_clk_gated: assert property (state_r == ST_WD || state_r == ST_HOLD |-> !ctrl.sysclk_en)
    else $error("system clock running before oscillator count");
  a_pin_filter: assert property (pin_req |-> $past(!sy_pin_n, 1) && $past(!sy_pin_n, 3))
    else $error("pin reset accepted too early");
  a_pin_flag: assert property (finish && is_sys_r && pend_r.pin |=> watchdog_control_reset_cause[4])
    else $error("pin cause flag not set");
  a_por_flag: assert property (finish && pend_r.por |=> watchdog_control_reset_cause[7])
    else $error("power-on cause flag not set");
  a_stop_rec: assert property (state_r == ST_IDLE && rec_req && !sys_req && !por_req
                               |=> state_r == ST_WD && ctrl.recovery)
    else $error("stop recovery not started");
  a_vector_go: assert property ($past(state_r) == ST_SYS && state_r == ST_IDLE |-> vector_fetch && !ctrl.cpu_idle)
    else $error("vector fetch missing at release");

endmodule : reset_stop_recovery_controller

/* File: rtl/sync_bits.sv */
`timescale 1ns/1ps
module sync_bits #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : sync_bits

/* File: tb/rst_pin_env.sv */
`timescale 1ns/1ps
module rst_pin_env
  import rstctl_pkg::*;
(
  input  wire logic              clk,
  input  wire rst_ctrl_t         ctrl,
  input  wire logic              vector_fetch,
  output logic                   supply_low,
  output logic                   supply_brownout_detect,
  output logic                   reset_pin_n,
  output logic                   debug_pin,
  output logic                   watchdog_timeout,
  output logic                   stop_mode,
  output logic      [GPIO_W-1:0] gpio_pins,
  output int                     fetches
);
  // supply starts below threshold, so the first sequence is a power-up
  logic [4:0] act_r = 5'h01;
  assign supply_low             = act_r[0];
  assign supply_brownout_detect = act_r[1];
  assign reset_pin_n            = ~act_r[2]; // pull-up: idle high
  assign debug_pin              = ~act_r[3];
  assign watchdog_timeout       = act_r[4];
  initial begin
    stop_mode = 1'b0;
    gpio_pins = 8'h00;
    fetches   = 0;
  end
  always @(posedge clk) begin
    if (ctrl.recovery === 1'b1) stop_mode <= 1'b0; // cpu leaves stop once recovery runs
    if (vector_fetch === 1'b1) fetches <= fetches + 1;
  end
  // hold one source active for n cycles; pin lows shorter than 4 are a deliberate fault
  task drive(input int which, input int n);
    @(posedge clk) act_r[which] <= 1'b1;
    repeat (n) @(posedge clk);
    act_r[which] <= 1'b0;
  endtask : drive
  task enter_stop;
    @(posedge clk) stop_mode <= 1'b1;
  endtask : enter_stop
  task flip_gpio(input int b);
    @(posedge clk) gpio_pins[b] <= ~gpio_pins[b];
  endtask : flip_gpio
endmodule : rst_pin_env

/* File: tb/tb_reset_stop_recovery_controller.sv */
`timescale 1ns/1ps
module tb_reset_stop_recovery_controller;
  import rstctl_pkg::*;
  localparam int WDD = 2;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              hsel, hwrite, hreadyout, hresp, wd_opt, vector_fetch, irq;
  logic              supply_low, brownout, pin_n, dbg_pin, stop_mode, wdt;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [GPIO_W-1:0] gpio, gpio_en;
  logic [7:0]        cause;
  logic [15:0]       vhi, vlo, r;
  rst_ctrl_t         ctrl, seen;
  int                fails = 0, n_checks = 0, wd_cnt = 0, sys_cnt = 0, seen_n = 0;
  int                fetches, exp_fetch = 0, i, b;
  int                exp_q[$];
  // model: cause flags per source; 0-3 and 7 are system resets, 4-6 recoveries
  logic [7:0]        cause_tbl[8] = '{8'h80, 8'h10, 8'h20, 8'h80, 8'h60, 8'h40, 8'h40, 8'h80};

  always #20 clk = ~clk;

  reset_stop_recovery_controller #(.WD_DIV(WDD)) dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .supply_low(supply_low), .supply_brownout_detect(brownout),
    .reset_pin_n(pin_n), .debug_pin(dbg_pin), .gpio_pins(gpio), .gpio_recovery_en(gpio_en),
    .stop_mode(stop_mode), .watchdog_timeout(wdt), .watchdog_reset_select_option(wd_opt),
    .ctrl(ctrl), .watchdog_control_reset_cause(cause), .vector_fetch(vector_fetch),
    .vector_addr_hi(vhi), .vector_addr_lo(vlo), .irq(irq));

  rst_pin_env env_u (
    .clk(clk), .ctrl(ctrl), .vector_fetch(vector_fetch), .supply_low(supply_low),
    .supply_brownout_detect(brownout), .reset_pin_n(pin_n), .debug_pin(dbg_pin),
    .watchdog_timeout(wdt), .stop_mode(stop_mode), .gpio_pins(gpio), .fetches(fetches));

  // a power event restarts everything, so phase lengths count from its end
  always @(posedge clk) begin
    if (supply_low | brownout) begin
      wd_cnt = 0;
      sys_cnt = 0;
      seen_n = 0;
    end else if (ctrl.cpu_idle === 1'b1) begin
      if (seen_n == 0) seen = ctrl;
      seen_n++;
      if (ctrl.sysclk_en) sys_cnt++;
      else wd_cnt++;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task print_verdict;
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask : chk

  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h00000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    chk(hresp, 1'b0, "bus response not okay");
  endtask : ahb

  task clear_counts;
    wd_cnt = 0;
    sys_cnt = 0;
    seen_n = 0;
  endtask : clear_counts

  task quiet(input int n);
    @(negedge clk) clear_counts();
    repeat (n) @(negedge clk);
    chk(wd_cnt + sys_cnt, 32'h0, "reset started without cause");
  endtask : quiet

  task expect_reset(input logic long_hold);
    int  src, k;
    logic sys;
    src = exp_q.pop_front();
    sys = (src < 4) || (src == 7);
    k = 0;
    while (vector_fetch !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    exp_fetch++;
    chk(k < 4000, 32'h1, "release never came");
    @(negedge clk);
    chk(cause, cause_tbl[src], "cause flags");
    chk(wd_cnt >= 65 * WDD && wd_cnt <= 67 * WDD + 4, 32'h1, "oscillator phase length");
    if (long_hold) chk(sys_cnt > 40, 32'h1, "held while pin low");
    else chk(sys_cnt, 32'h10, "clock phase length");
    if (sys) chk({seen[5:3], seen[1:0]}, 5'b10111, "system reset controls");
    else chk(seen[5:3], 3'b011, "recovery controls");
    chk(fetches, exp_fetch, "vector fetch count");
    chk({vhi, vlo}, 32'h00020003, "vector addresses");
    ahb(1'b0, ADDR_WD_CAUSE, 32'h0, rd);
    chk(rd[7:0], cause_tbl[src], "cause over bus");
    ahb(1'b0, ADDR_INT_STATUS, 32'h0, rd);
    chk(rd[1:0], sys ? 2'h1 : 2'h2, "done status");
    if (exp_fetch == 1) chk(irq, 1'b0, "irq while masked");
    ahb(1'b1, ADDR_INT_MASK, 32'h3, rd);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1, "irq unmasked");
    ahb(1'b1, ADDR_INT_STATUS, 32'h3, rd);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0, "irq after clear");
    clear_counts();
  endtask : expect_reset

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, gpio_en} = '0;
    hsize  = 3'h2;
    wd_opt = 1'b1;
    r      = 16'hFB45;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    exp_q.push_back(0);
    env_u.drive(0, 20);
    expect_reset(1'b0);
    env_u.drive(2, 3);
    quiet(40);
    exp_q.push_back(1);
    env_u.drive(2, 200);
    expect_reset(1'b1);
    @(posedge clk) wd_opt <= 1'b0;
    env_u.drive(4, 1);
    quiet(20);
    @(posedge clk) wd_opt <= 1'b1;
    exp_q.push_back(2);
    env_u.drive(4, 1);
    expect_reset(1'b0);
    exp_q.push_back(3);
    ahb(1'b1, ADDR_DEBUG_CTRL, 32'h1, rd);
    expect_reset(1'b0);
    ahb(1'b0, ADDR_DEBUG_CTRL, 32'h0, rd);
    chk(rd[DEBUG_RST_BIT], 1'b0, "debugger bit self-clears");
    for (i = 4; i < 8; i++) begin
      r = lfsr(r);
      b = int'(r[2:0]);
      @(posedge clk) gpio_en <= 8'h01 << b;
      env_u.enter_stop();
      if (i == 5) begin
        env_u.flip_gpio((b + 1) % 8);
        quiet(20);
      end
      exp_q.push_back(i);
      case (i)
        4: env_u.drive(4, 1);
        5: env_u.flip_gpio(b);
        6: env_u.drive(3, 5);
        default: begin
          env_u.drive(4, 1);
          repeat (20 + int'(r[6:3])) @(posedge clk);
          env_u.drive(1, 5);
        end
      endcase
      expect_reset(1'b0);
    end
    ahb(1'b0, 12'h200, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    ahb(1'b1, ADDR_WD_CAUSE, 32'hFF, rd);
    ahb(1'b0, ADDR_WD_CAUSE, 32'h0, rd);
    chk(rd[7:0], 8'h80, "cause register is read-only");
    print_verdict();
  end
endmodule : tb_reset_stop_recovery_controller
